// >>> core/pspio_defs.svh
`ifndef PSPIO_DEFS_SVH
`define PSPIO_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define IDX_DATA_PORT 8'h08
`define IDX_CTRL_PORT 8'h09
`define IDX_DATA_DIR  8'h88
`define IDX_CTRL_STAT 8'h89
`define IDX_ANA_CFG   8'h9F

// ---------------------------------------------------------------
// field positions of control_direction_and_slave_status
// ---------------------------------------------------------------
`define BIT_IN_FULL   7
`define BIT_OUT_FULL  6
`define BIT_OVERFLOW  5
`define BIT_SLAVE_SEL 4

// ---------------------------------------------------------------
// reset values and analog selection
// ---------------------------------------------------------------
`define RST_DATA_DIR  8'hFF
`define RST_CTRL_DIR  3'h7
`define RST_ANA_CFG   3'h0
`define RST_LATCH     8'h00
`define CFG_DIGITAL   3'h7

`endif

// >>> core/pspio_pkg.sv
package pspio_pkg;

  // avalon handshake: one wait cycle, then the acknowledge cycle
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage

// >>> core/pspio.sv
`timescale 1ns/10ps
`default_nettype none
`include "pspio_defs.svh"

module pspio #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // avalon-mm slave, byte address
  input  wire logic [9:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  // data pins
  input  wire logic [7:0]  PD_IN,
  output logic      [7:0]  PD_OUT,
  output logic      [7:0]  PD_OE,
  // control pins: 2 chip select, 1 write, 0 read (all low active)
  input  wire logic [2:0]  PE_IN,
  output logic      [2:0]  PE_OUT,
  output logic      [2:0]  PE_OE
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  generate
    if (PORT_W != 8) begin : g_width_check
      $error("pspio serves an 8-bit data port only");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pspio_pkg::bus_state_t bus;
    logic                  wreq;
    logic [31:0]           rdata;
    logic [7:0]            out_lat;
    logic [7:0]            in_lat;
    logic [7:0]            pd_dir;
    logic [2:0]            pe_lat;
    logic [2:0]            pe_dir;
    logic                  mode;
    logic                  input_full_flag;
    logic                  output_full_flag;
    logic                  input_overflow_flag;
    logic [2:0]            acfg;
    logic                  wr_act;
    logic                  rd_act;
    logic                  pend;
    logic [7:0]            pd_oe;
    logic [2:0]            pe_oe;
  } state_t;

  state_t q;
  state_t d;

  logic       digital;
  logic       slave_on;
  logic       wr_now;
  logic       rd_now;
  logic       req;
  logic       commit;
  logic [7:0] idx;

  // ---------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------
  assign digital  = (q.acfg == `CFG_DIGITAL);
  assign slave_on = q.mode & digital;
  // strobes count only while chip select is low
  assign wr_now   = slave_on & ~PE_IN[2] & ~PE_IN[1];
  assign rd_now   = slave_on & ~PE_IN[2] & ~PE_IN[0];
  assign req      = READ | WRITE;
  assign commit   = req & (q.bus == pspio_pkg::BUS_ACK);
  assign idx      = ADDRESS[9:2];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // ---------------------------------------------------------------
    // bus handshake
    // ---------------------------------------------------------------
    case (q.bus)
      pspio_pkg::BUS_IDLE: begin
        if (req) begin
          d.bus = pspio_pkg::BUS_ACK;
        end
      end
      pspio_pkg::BUS_ACK: begin
        d.bus = pspio_pkg::BUS_IDLE;
      end
      default: begin
        d.bus = pspio_pkg::BUS_IDLE;
      end
    endcase
    d.wreq = (d.bus != pspio_pkg::BUS_ACK);

    // ---------------------------------------------------------------
    // register read
    // ---------------------------------------------------------------
    // read data is prepared in the wait cycle and held for the ack
    if (READ && q.bus == pspio_pkg::BUS_IDLE) begin
      d.rdata = 32'h0;
      case (idx)
        `IDX_DATA_PORT: begin
          // slave mode shows the input latch, else the pins
          d.rdata[7:0] = q.mode ? q.in_lat : PD_IN;
        end
        `IDX_CTRL_PORT: begin
          d.rdata[2:0] = PE_IN & {3{digital}};
        end
        `IDX_DATA_DIR: begin
          d.rdata[7:0] = q.pd_dir;
        end
        `IDX_CTRL_STAT: begin
          // bit 3 stays zero
          d.rdata[7:0] = {q.input_full_flag, q.output_full_flag, q.input_overflow_flag, q.mode,
                          1'b0, q.pe_dir};
        end
        `IDX_ANA_CFG: begin
          d.rdata[2:0] = q.acfg;
        end
        default: begin
          d.rdata = 32'h0;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // register write
    // ---------------------------------------------------------------
    // software side effects at the acknowledge edge
    if (commit && WRITE) begin
      case (idx)
        `IDX_DATA_PORT: begin
          d.out_lat = WRITEDATA[7:0];
          // a write during an external read leaves the flag clear
          if (!rd_now) begin
            d.output_full_flag = 1'b1;
          end
        end
        `IDX_CTRL_PORT: begin
          d.pe_lat = WRITEDATA[2:0];
        end
        `IDX_DATA_DIR: begin
          d.pd_dir = WRITEDATA[7:0];
        end
        `IDX_CTRL_STAT: begin
          d.input_overflow_flag   = WRITEDATA[`BIT_OVERFLOW];
          d.mode   = WRITEDATA[`BIT_SLAVE_SEL];
          d.pe_dir = WRITEDATA[2:0];
        end
        `IDX_ANA_CFG: begin
          d.acfg = WRITEDATA[2:0];
        end
        default: begin
        end
      endcase
    end
    if (commit && READ && idx == `IDX_DATA_PORT && q.mode) begin
      d.input_full_flag = 1'b0;
    end

    // ---------------------------------------------------------------
    // slave link
    // ---------------------------------------------------------------
    // external write: track pins while active, flag two cycles after end
    d.wr_act = wr_now;
    d.rd_act = rd_now;
    if (wr_now) begin
      d.in_lat = PD_IN;
    end
    d.pend = q.wr_act & ~wr_now;
    if (q.pend) begin
      d.input_full_flag = 1'b1;
      if (q.input_full_flag) begin
        d.input_overflow_flag = 1'b1;
      end
    end
    // external read start empties the output buffer
    if (rd_now && !q.rd_act) begin
      d.output_full_flag = 1'b0;
    end

    // ---------------------------------------------------------------
    // mode policy
    // ---------------------------------------------------------------
    // plain i/o mode: full flags held clear, overflow untouched
    if (!d.mode) begin
      d.input_full_flag = 1'b0;
      d.output_full_flag = 1'b0;
    end

    // ---------------------------------------------------------------
    // pin drivers
    // ---------------------------------------------------------------
    if (d.mode) begin
      // strobes alone decide; released one cycle after read ends
      d.pd_oe = {8{rd_now}};
    end else begin
      d.pd_oe = ~d.pd_dir;
    end
    // direction bits rule even for analog or strobe pins
    d.pe_oe = ~d.pe_dir;

    // ---------------------------------------------------------------
    // reset
    // ---------------------------------------------------------------
    if (RESET) begin
      d.bus    = pspio_pkg::BUS_IDLE;
      d.wreq   = 1'b1;
      d.rdata  = 32'h0;
      // latches have no defined value; zero keeps simulation clean
      d.out_lat = `RST_LATCH;
      d.in_lat  = `RST_LATCH;
      d.pe_lat  = 3'h0;
      d.pd_dir = `RST_DATA_DIR;
      d.pe_dir = `RST_CTRL_DIR;
      d.mode   = 1'b0;
      d.input_full_flag    = 1'b0;
      d.output_full_flag    = 1'b0;
      d.input_overflow_flag   = 1'b0;
      d.acfg   = `RST_ANA_CFG;
      d.wr_act = 1'b0;
      d.rd_act = 1'b0;
      d.pend   = 1'b0;
      d.pd_oe  = 8'h00;
      d.pe_oe  = 3'h0;
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign READDATA    = q.rdata;
  assign WAITREQUEST = q.wreq;
  assign PD_OUT      = q.out_lat;
  assign PD_OE       = q.pd_oe;
  assign PE_OUT      = q.pe_lat;
  assign PE_OE       = q.pe_oe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_dir_reset: assert property (
    $past(RESET) |-> q.pd_dir == 8'hFF
    && q.pe_dir == 3'h7 && !q.mode)
    else $error("directions not reset");
  // a write that leaves slave mode hands the pins back to the direction bits
  a_read_drive: assert property (rd_now |=> !q.mode || PD_OE == 8'hFF)
    else $error("read strobe did not drive data pins");
  a_read_release: assert property (q.mode && !rd_now |=> !q.mode || PD_OE == 8'h00)
    else $error("data pins not released");
  a_obf_clear: assert property (rd_now && !q.rd_act |=> !q.output_full_flag)
    else $error("output full not cleared on read");
  a_ibf_set: assert property (
    q.wr_act && !wr_now |=> ##1
    (q.input_full_flag || !q.mode))
    else $error("input full not set after write");
  a_input_overflow_flag_set: assert property (q.pend && q.input_full_flag |=> q.input_overflow_flag)
    else $error("overflow not flagged");
  a_gpio_flags: assert property (!q.mode |-> !q.input_full_flag && !q.output_full_flag)
    else $error("full flags set outside slave mode");
  a_analog_zero: assert property (
    READ && q.bus == pspio_pkg::BUS_IDLE
    && idx == `IDX_CTRL_PORT && !digital |=> READDATA[2:0] == 3'h0)
    else $error("analog control pin read nonzero");
  a_bit3_zero: assert property (
    READ && q.bus == pspio_pkg::BUS_IDLE
    && idx == `IDX_CTRL_STAT |=> READDATA[3] == 1'b0)
    else $error("unimplemented bit reads one");
  a_bus_ack: assert property (req && q.bus == pspio_pkg::BUS_IDLE
    |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus acknowledge malformed");
  a_pd_out_load: assert property (
    commit && WRITE && idx == `IDX_DATA_PORT
    |=> PD_OUT == $past(WRITEDATA[7:0]))
    else $error("output latch not loaded");
  a_pe_out_load: assert property (
    commit && WRITE && idx == `IDX_CTRL_PORT
    |=> PE_OUT == $past(WRITEDATA[2:0]))
    else $error("control latch not loaded");
  a_mode_write: assert property (
    commit && WRITE && idx == `IDX_CTRL_STAT
    |=> q.mode == $past(WRITEDATA[4]))
    else $error("slave select not written");
  a_dir_write: assert property (
    commit && WRITE && idx == `IDX_CTRL_STAT
    |=> q.pe_dir == $past(WRITEDATA[2:0]))
    else $error("control directions not written");
  a_gpio_oe: assert property (
    !q.mode
    |-> PD_OE == ~q.pd_dir)
    else $error("data drive differs from direction");

  // ---------------------------------------------------------------
  // assertions on control drive, the slave link and overflow in plain i/o
  // ---------------------------------------------------------------
  a_ctrl_oe: assert property (
    1'b1
    |-> PE_OE == ~q.pe_dir)
    else $error("control drive differs from direction");
  a_in_latch: assert property (
    wr_now
    |=> q.in_lat == $past(PD_IN))
    else $error("input latch missed the pins");
  a_cs_ignore: assert property (
    PE_IN[2]
    |=> !q.wr_act && !q.rd_act)
    else $error("strobe taken without chip select");
  a_analog_gate: assert property (
    !digital
    |=> !q.wr_act && !q.rd_act)
    else $error("strobe taken on analog pins");
  a_ibf_clear: assert property (
    commit && READ && idx == `IDX_DATA_PORT && q.mode && !q.pend
    |=> !q.input_full_flag)
    else $error("input full not cleared by read");
  a_obf_set: assert property (
    commit && WRITE && idx == `IDX_DATA_PORT && q.mode && !rd_now
    |=> q.output_full_flag)
    else $error("output full not set by write");
  // only a software write may move overflow while the port is plain i/o
  a_input_overflow_flag_keep: assert property (
    !q.mode && !(commit && WRITE)
    |=> q.input_overflow_flag == $past(q.input_overflow_flag))
    else $error("overflow moved outside slave mode");

  // ---------------------------------------------------------------
  // cover
  // ---------------------------------------------------------------
  c_ext_write: cover property (q.wr_act && !wr_now);
  c_ext_read:  cover property (rd_now && !q.rd_act && q.output_full_flag);
  c_overflow:  cover property (!q.input_overflow_flag ##1 q.input_overflow_flag);
  c_ovf_clear: cover property (q.input_overflow_flag ##1 !q.input_overflow_flag);
  c_gpio_out:  cover property (!q.mode && PD_OE != 8'h00);

endmodule
`default_nettype wire

// >>> bench/ext_master.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far-side microprocessor bus model
// ----------------------------------------
module ext_master (
  // clock
  input  wire logic       CLK,
  // device pin drivers
  input  wire logic [7:0] PD_OUT,
  input  wire logic [7:0] PD_OE,
  input  wire logic [2:0] PE_OUT,
  input  wire logic [2:0] PE_OE,
  // resolved wire levels
  output logic      [7:0] PD_WIRE,
  output logic      [2:0] PE_WIRE
);
  // [2] select, [1] write, [0] read, all idle high
  logic [2:0] strb_n = 3'h7;
  logic [7:0] dat    = 8'h3C;
  // a released data bus shows the inverse of the last value, not a stale copy
  assign PD_WIRE = (PD_OE & PD_OUT) | (~PD_OE & dat);
  assign PE_WIRE = (PE_OE & PE_OUT) | (~PE_OE & strb_n);

  task automatic wr(input logic [7:0] b, input logic cs_n);
    @(posedge CLK);
    strb_n <= {cs_n, 2'b01};
    dat    <= b;
    @(posedge CLK);
    strb_n <= 3'h7;
    @(posedge CLK);
    dat <= ~b;
    // idle gap so the full flag lands before the next strobe
    repeat (3) @(posedge CLK);
  endtask

  task automatic rd(input int hold, output logic [7:0] q);
    @(posedge CLK);
    strb_n <= 3'h2;
    repeat (hold) @(posedge CLK);
    @(negedge CLK);
    q = PD_WIRE;
    @(posedge CLK);
    strb_n <= 3'h7;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_pspio.sv
`timescale 1ns/10ps
`default_nettype none
`include "pspio_defs.svh"
module tb_pspio;
  logic        CLK       = 1'b0;
  logic        RESET     = 1'b1;
  logic [9:0]  ADDRESS   = 10'h000;
  logic        READ      = 1'b0;
  logic        WRITE     = 1'b0;
  logic [31:0] WRITEDATA = 32'h00000000;
  logic [31:0] READDATA;
  logic        WAITREQUEST;
  logic [7:0]  PD_IN;
  logic [7:0]  PD_OUT;
  logic [7:0]  PD_OE;
  logic [2:0]  PE_IN;
  logic [2:0]  PE_OUT;
  logic [2:0]  PE_OE;
  int          mismatches = 0;
  int          cmp_count  = 0;
  logic [7:0]  q;

  pspio i_dut (.CLK(CLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .PD_IN(PD_IN), .PD_OUT(PD_OUT),
    .PD_OE(PD_OE), .PE_IN(PE_IN), .PE_OUT(PE_OUT), .PE_OE(PE_OE));
  ext_master i_ext (.CLK(CLK), .PD_OUT(PD_OUT), .PD_OE(PD_OE),
    .PE_OUT(PE_OUT), .PE_OE(PE_OE), .PD_WIRE(PD_IN), .PE_WIRE(PE_IN));

  initial forever #2.5 CLK = ~CLK;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge CLK);
    ADDRESS   <= {idx, 2'b00};
    WRITE     <= w;
    READ      <= ~w;
    WRITEDATA <= {24'h000000, d};
    // read just after the edge, before that edge's update lands, so a low
    // value is the edge that takes the access; only the watchdog ends a hang
    do begin
      @(posedge CLK);
    end while (WAITREQUEST !== 1'b0);
    q = READDATA[7:0];
    READ  <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rc(input string n, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(n, e, q);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rc("data_dir", `IDX_DATA_DIR, 8'hFF);
    rc("ctrl_stat", `IDX_CTRL_STAT, 8'h07);
    rc("ana_cfg", `IDX_ANA_CFG, 8'h00);
    rc("ctrl_port", `IDX_CTRL_PORT, 8'h00);
    rc("unmapped", 8'h00, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_gpio;
    wr(`IDX_DATA_DIR, 8'h0F);
    wr(`IDX_DATA_PORT, 8'hA5);
    rc("pd_pins", `IDX_DATA_PORT, 8'hA0 | (i_ext.dat & 8'h0F));
    @(negedge CLK);
    chk("pd_oe", 8'hF0, PD_OE);
    chk("pd_out", 8'hA5, PD_OUT);
    wr(`IDX_CTRL_PORT, 8'h05);
    wr(`IDX_CTRL_STAT, 8'h02);
    rc("ctrl_analog", `IDX_CTRL_PORT, 8'h00);
    @(negedge CLK);
    chk("pe_oe", 8'h05, {5'h00, PE_OE});
    chk("pe_out", 8'h05, {5'h00, PE_OUT});
    wr(`IDX_CTRL_STAT, 8'h0F);
    rc("bit3", `IDX_CTRL_STAT, 8'h07);
    wr(`IDX_ANA_CFG, 8'h07);
    rc("ctrl_digital", `IDX_CTRL_PORT, 8'h07);
    $display("test gpio done");
  endtask

  task automatic t_swrite;
    wr(`IDX_CTRL_STAT, 8'h17);
    i_ext.wr(8'h3C, 1'b0);
    rc("stat_ibf", `IDX_CTRL_STAT, 8'h97);
    i_ext.wr(8'hC3, 1'b0);
    rc("stat_ovf", `IDX_CTRL_STAT, 8'hB7);
    rc("in_latch", `IDX_DATA_PORT, 8'hC3);
    rc("stat_rd", `IDX_CTRL_STAT, 8'h37);
    wr(`IDX_CTRL_STAT, 8'h17);
    rc("stat_clr", `IDX_CTRL_STAT, 8'h17);
    i_ext.wr(8'h66, 1'b1);
    rc("cs_high", `IDX_CTRL_STAT, 8'h17);
    wr(`IDX_ANA_CFG, 8'h03);
    i_ext.wr(8'h66, 1'b0);
    rc("analog_pins", `IDX_CTRL_STAT, 8'h17);
    wr(`IDX_ANA_CFG, 8'h07);
    $display("test slave write done");
  endtask

  task automatic t_sread;
    wr(`IDX_DATA_DIR, 8'h00);
    wr(`IDX_DATA_PORT, 8'h5A);
    rc("stat_obf", `IDX_CTRL_STAT, 8'h57);
    @(negedge CLK);
    chk("oe_idle", 8'h00, PD_OE);
    i_ext.rd(2, q);
    chk("ext_rd", 8'h5A, q);
    repeat (3) @(negedge CLK);
    chk("oe_release", 8'h00, PD_OE);
    rc("stat_obf0", `IDX_CTRL_STAT, 8'h17);
    wr(`IDX_DATA_PORT, 8'h96);
    i_ext.rd(4, q);
    chk("ext_rd_slow", 8'h96, q);
    $display("test slave read done");
  endtask

  task automatic t_mode_off;
    i_ext.wr(8'h11, 1'b0);
    i_ext.wr(8'h22, 1'b0);
    wr(`IDX_DATA_PORT, 8'h33);
    rc("stat_all", `IDX_CTRL_STAT, 8'hF7);
    wr(`IDX_CTRL_STAT, 8'h27);
    rc("stat_gpio", `IDX_CTRL_STAT, 8'h27);
    $display("test mode off done");
  endtask

  task automatic t_rereset;
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
    t_gpio;
    t_swrite;
    t_sread;
    t_mode_off;
    t_rereset;
    tally_and_finish;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge CLK);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
